/* shared/dsd_pkg.sv */
// Constants, types and decode helpers for the data space decoder
// Summary of operation
// - Decode 32 register, 64 I/O, 160 extended I/O, 2048 SRAM locations in order.
// - Port I/O uses addresses 0x00-0x3F; data space sees them at plus 0x20.
// - Bit set, clear and skip reach only I/O addresses 0x00-0x1F.
// - Single-bit operations write only the addressed bit, nothing else.
// - Extended I/O 0x60-0xFF only through loads and stores, never port I/O.
// - Internal SRAM access completes in two clock cycles.
// - Some status flags clear on writing one; writing zero leaves them.
// - Displacement mode adds up to 63 to the second or third pointer.
// - Pre-decrement before use, post-increment after use, both written back.
// - Registers 26 to 31 form three 16-bit pointers from register pairs.
// - Direct addressing reaches every data space location.
// - Three side-effect-free storage registers; low-range ones are bit-accessible.
package dsd_pkg;
    // Region bases in the linear data space
    localparam logic [15:0] STD_IO_BASE = 16'h0020;
    localparam logic [15:0] EXT_IO_BASE = 16'h0060;
    localparam logic [15:0] SRAM_BASE   = 16'h0100;
    localparam logic [15:0] SPACE_END   = 16'h0900;
    localparam int          SRAM_AW     = 11;
    localparam int          SRAM_DEPTH  = 2048;
    localparam int          RF_DEPTH    = 32;
    // I/O numbering
    localparam logic [15:0] IO_DATA_OFS = 16'h0020;
    localparam logic [15:0] IO_PORT_MAX = 16'h003F;
    localparam logic [15:0] BIT_IO_MAX  = 16'h001F;
    localparam logic [15:0] PTR_STEP    = 16'h0001;
    // Pointer pair low registers
    localparam logic [4:0]  PTR_X_LO    = 5'h1A;
    localparam logic [4:0]  PTR_Y_LO    = 5'h1C;
    localparam logic [4:0]  PTR_Z_LO    = 5'h1E;
    // I/O registers held here, as data addresses
    localparam logic [7:0]  FLAG_ADDR   = 8'h3C;
    localparam logic [7:0]  GPR0_ADDR   = 8'h3E;
    localparam logic [7:0]  GPR1_ADDR   = 8'h4A;
    localparam logic [7:0]  GPR2_ADDR   = 8'h4B;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [7:0]  FULL_MASK   = 8'hFF;
    localparam int          SRAM_CYCLES = 2;

    typedef enum logic [3:0] {
        addr_direct, addr_disp, addr_indirect, addr_predec, addr_postinc,
        io_port_op, set_io_bit_op, clear_io_bit_op,
        skip_if_io_bit_one, skip_if_io_bit_zero
    } dsd_mode_type;
    typedef enum logic {data_load_ops, data_store_ops} dsd_dir_type;
    typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} dsd_ptr_type;
    typedef enum logic [2:0] {
        region_none, region_regfile, region_std_io, region_ext_io, region_sram
    } dsd_region_type;

    // Linear address to region
    function automatic dsd_region_type region_of(input logic [15:0] a);
        if (a < STD_IO_BASE) begin
            region_of = region_regfile;
        end else if (a < EXT_IO_BASE) begin
            region_of = region_std_io;
        end else if (a < SRAM_BASE) begin
            region_of = region_ext_io;
        end else if (a < SPACE_END) begin
            region_of = region_sram;
        end else begin
            region_of = region_none;
        end
    endfunction : region_of

    // Low register of a pointer pair
    function automatic logic [4:0] ptr_lo(input dsd_ptr_type s);
        if (s == ptr_y) begin
            ptr_lo = PTR_Y_LO;
        end else if (s == ptr_z) begin
            ptr_lo = PTR_Z_LO;
        end else begin
            ptr_lo = PTR_X_LO;
        end
    endfunction : ptr_lo

    // Masked merge: only bits under m change
    function automatic logic [7:0] merge_bits(input logic [7:0] old,
                                              input logic [7:0] d,
                                              input logic [7:0] m);
        merge_bits = (old & ~m) | (d & m);
    endfunction : merge_bits
endpackage : dsd_pkg

/* shared/dsd_io_if.sv */
// I/O register access channel between decoder and I/O register bank
`timescale 1ns/100ps
interface dsd_io_if;
    logic       en;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic [7:0] rdata;
    modport cpu (output en, we, addr, wdata, wmask, input rdata);
    modport regs (input en, we, addr, wdata, wmask, output rdata);
endinterface : dsd_io_if

/* src/dsd_addr_gen.sv */
// Effective address and pointer update for all addressing modes
`timescale 1ns/100ps
module dsd_addr_gen (
    input  dsd_pkg::dsd_mode_type mode,     // Addressing mode
    input  logic [15:0]           ptr_val,  // Selected pointer
    input  logic [5:0]            disp,     // Unsigned displacement
    input  logic [15:0]           addr_in,  // Direct or I/O address
    output logic [15:0]           eff_addr, // Effective data address
    output logic [15:0]           ptr_new,  // Updated pointer
    output logic                  ptr_wb    // Pointer write-back
);
    // Mode decode, purely combinational
    always_comb begin
        eff_addr = addr_in;
        ptr_new  = ptr_val;
        ptr_wb   = 1'b0;
        case (mode)
            dsd_pkg::addr_disp: begin
                eff_addr = ptr_val + {10'h000, disp};
            end
            dsd_pkg::addr_indirect: begin
                eff_addr = ptr_val;
            end
            dsd_pkg::addr_predec: begin
                eff_addr = ptr_val - dsd_pkg::PTR_STEP;
                ptr_new  = ptr_val - dsd_pkg::PTR_STEP;
                ptr_wb   = 1'b1;
            end
            dsd_pkg::addr_postinc: begin
                eff_addr = ptr_val;
                ptr_new  = ptr_val + dsd_pkg::PTR_STEP;
                ptr_wb   = 1'b1;
            end
            dsd_pkg::io_port_op, dsd_pkg::set_io_bit_op, dsd_pkg::clear_io_bit_op,
            dsd_pkg::skip_if_io_bit_one, dsd_pkg::skip_if_io_bit_zero: begin
                eff_addr = addr_in + dsd_pkg::IO_DATA_OFS;
            end
            default: begin
                eff_addr = addr_in;
            end
        endcase
    end
endmodule : dsd_addr_gen

/* src/dsd_io_regs.sv */
// I/O register bank: storage registers and write-one-to-clear flags
`timescale 1ns/100ps
module dsd_io_regs (
    input  logic       mclk,     // CPU clock
    input  logic       rst_n,    // Async reset, active low
    dsd_io_if.regs     bus,      // Access channel
    input  logic [7:0] flag_set, // Hardware flag events
    output logic [7:0] flags     // Flag register state
);
    typedef struct packed {
        logic [7:0] gpr0;
        logic [7:0] gpr1;
        logic [7:0] gpr2;
        logic [7:0] flags;
    } dsd_io_state_type;

    dsd_io_state_type r;
    dsd_io_state_type n;
    logic [7:0]       clr;
    logic             wr;

    assign wr    = bus.en && bus.we;
    assign flags = r.flags;

    // Read mux, writes merged under mask
    always_comb begin
        n   = r;
        clr = 8'h00;
        if (bus.addr == dsd_pkg::FLAG_ADDR) begin
            bus.rdata = r.flags;
        end else if (bus.addr == dsd_pkg::GPR0_ADDR) begin
            bus.rdata = r.gpr0;
        end else if (bus.addr == dsd_pkg::GPR1_ADDR) begin
            bus.rdata = r.gpr1;
        end else if (bus.addr == dsd_pkg::GPR2_ADDR) begin
            bus.rdata = r.gpr2;
        end else begin
            bus.rdata = 8'h00;
        end
        if (wr) begin
            if (bus.addr == dsd_pkg::FLAG_ADDR) begin
                clr = bus.wdata & bus.wmask;
            end else if (bus.addr == dsd_pkg::GPR0_ADDR) begin
                n.gpr0 = dsd_pkg::merge_bits(r.gpr0, bus.wdata, bus.wmask);
            end else if (bus.addr == dsd_pkg::GPR1_ADDR) begin
                n.gpr1 = dsd_pkg::merge_bits(r.gpr1, bus.wdata, bus.wmask);
            end else if (bus.addr == dsd_pkg::GPR2_ADDR) begin
                n.gpr2 = dsd_pkg::merge_bits(r.gpr2, bus.wdata, bus.wmask);
            end
            // Unused addresses drop the write, so stray stores do no harm
        end
        // Event wins over a clear in the same cycle
        n.flags = (r.flags & ~clr) | flag_set;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= {4{dsd_pkg::REG_RESET}};
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_w1c_clear;
        wr && bus.addr == dsd_pkg::FLAG_ADDR
            |=> ((r.flags & $past(clr)) & ~$past(flag_set)) == 8'h00;
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("flag written with one did not clear");

    property p_w1c_keep;
        wr && bus.addr == dsd_pkg::FLAG_ADDR
            |=> ((r.flags ^ $past(r.flags)) & ~$past(clr) & ~$past(flag_set)) == 8'h00;
    endproperty
    a_w1c_keep: assert property (p_w1c_keep)
        else $error("flag changed without a one written");

    property p_bit_only;
        wr && bus.addr == dsd_pkg::GPR0_ADDR
            |=> ((r.gpr0 ^ $past(r.gpr0)) & ~$past(bus.wmask)) == 8'h00;
    endproperty
    a_bit_only: assert property (p_bit_only)
        else $error("bits outside the write mask changed");
endmodule : dsd_io_regs

/* src/dsd_data_space.sv */
// Data space decoder: regions, register file, SRAM and access sequencing
`timescale 1ns/100ps
module dsd_data_space (
    input  logic                  mclk,        // CPU clock, 200 MHz
    input  logic                  rst_n,       // Async reset, active low
    input  logic                  acc_req,     // Access request
    input  dsd_pkg::dsd_dir_type  acc_dir,     // Load or store
    input  dsd_pkg::dsd_mode_type acc_mode,    // Addressing mode
    input  logic [15:0]           acc_addr,    // Direct or I/O address
    input  dsd_pkg::dsd_ptr_type  acc_ptr_sel, // Pointer pair
    input  logic [5:0]            acc_disp,    // Displacement
    input  logic [2:0]            acc_bit,     // Bit number
    input  logic [7:0]            acc_wdata,   // Store data
    input  logic [7:0]            hw_flag_set, // Flag events
    output logic [7:0]            acc_rdata,   // Load data
    output logic                  acc_done,    // Access complete
    output logic                  acc_err,     // Access refused
    output logic                  acc_skip,    // Skip condition met
    output logic                  acc_busy,    // SRAM access underway
    output logic                  sel_regfile, // Register file region
    output logic                  sel_std_io,  // Standard I/O region
    output logic                  sel_ext_io,  // Extended I/O region
    output logic                  sel_sram,    // SRAM region
    output logic [15:0]           eff_addr,    // Effective address
    output logic [7:0]            io_flags     // Flag register
);
    typedef enum logic {st_idle, st_sram} dsd_state_type;

    typedef struct packed {
        dsd_state_type         state;
        dsd_pkg::dsd_ptr_type  ptr_sel;
        logic [15:0]           eff_addr;
        logic                  store;
        logic [7:0]            wdata;
        logic [7:0]            rdata;
        logic                  done;
        logic                  err;
        logic                  skip;
        logic                  busy;
        logic                  sel_rf;
        logic                  sel_std;
        logic                  sel_ext;
        logic                  sel_sram;
    } dsd_main_type;

    dsd_main_type r;
    dsd_main_type n;

    logic [7:0] rf_mem [dsd_pkg::RF_DEPTH];
    logic [7:0] sram_mem [dsd_pkg::SRAM_DEPTH];

    dsd_io_if io ();

    logic                     take;
    logic                     take_sram;
    logic                     fault;
    logic                     is_port;
    logic                     is_bit;
    logic                     is_store;
    logic [4:0]               plo;
    logic [4:0]               phi;
    logic [15:0]              ptr_val;
    logic [15:0]              ptr_now;
    logic [15:0]              gen_eff;
    logic [15:0]              gen_ptr;
    logic                     gen_wb;
    logic [7:0]               bit_mask;
    dsd_pkg::dsd_region_type  region;
    logic                     rf_we;
    logic [7:0]               rf_wdat;
    logic                     ptr_we;
    logic                     sram_we;
    logic [15:0]              sram_ofs;
    logic [dsd_pkg::SRAM_AW-1:0] sram_idx;

    // Pointer pair for the selected register couple
    assign plo     = dsd_pkg::ptr_lo(acc_ptr_sel);
    assign phi     = {plo[4:1], 1'b1};
    assign ptr_val = {rf_mem[phi], rf_mem[plo]};

    dsd_addr_gen u_addr_gen (
        .mode     (acc_mode),
        .ptr_val  (ptr_val),
        .disp     (acc_disp),
        .addr_in  (acc_addr),
        .eff_addr (gen_eff),
        .ptr_new  (gen_ptr),
        .ptr_wb   (gen_wb)
    );

    dsd_io_regs u_io_regs (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .bus      (io.regs),
        .flag_set (hw_flag_set),
        .flags    (io_flags)
    );

    // Instruction class decode
    assign is_port = acc_mode == dsd_pkg::io_port_op;
    assign is_bit  = acc_mode == dsd_pkg::set_io_bit_op
                  || acc_mode == dsd_pkg::clear_io_bit_op
                  || acc_mode == dsd_pkg::skip_if_io_bit_one
                  || acc_mode == dsd_pkg::skip_if_io_bit_zero;
    assign is_store = acc_mode == dsd_pkg::set_io_bit_op
                   || acc_mode == dsd_pkg::clear_io_bit_op
                   || (!is_bit && acc_dir == dsd_pkg::data_store_ops);
    assign bit_mask = 8'h01 << acc_bit;
    assign region   = dsd_pkg::region_of(gen_eff);

    // Refusals: port I/O beyond 64, bit ops beyond 32, X with displacement, addresses past the space end
    assign fault = (is_port && acc_addr > dsd_pkg::IO_PORT_MAX)
                || (is_bit && acc_addr > dsd_pkg::BIT_IO_MAX)
                || (acc_mode == dsd_pkg::addr_disp && acc_ptr_sel == dsd_pkg::ptr_x)
                || region == dsd_pkg::region_none;

    assign take      = r.state == st_idle && acc_req;
    assign take_sram = take && !fault && region == dsd_pkg::region_sram;

    // SRAM index from the latched address, used by both read and write
    assign sram_ofs = r.eff_addr - dsd_pkg::SRAM_BASE;
    assign sram_idx = sram_ofs[dsd_pkg::SRAM_AW-1:0];

    // Next state, access steering and I/O channel drive
    always_comb begin
        n        = r;
        n.done   = 1'b0;
        n.err    = 1'b0;
        rf_we    = 1'b0;
        rf_wdat  = acc_wdata;
        ptr_we   = 1'b0;
        sram_we  = 1'b0;
        io.en    = 1'b0;
        io.we    = 1'b0;
        io.addr  = gen_eff[7:0];
        io.wdata = acc_wdata;
        io.wmask = dsd_pkg::FULL_MASK;
        case (r.state)
            st_idle: begin
                if (acc_req) begin
                    n.eff_addr = gen_eff;
                    n.ptr_sel  = acc_ptr_sel;
                    n.store    = is_store;
                    n.wdata    = acc_wdata;
                    n.skip     = 1'b0;
                    n.sel_rf   = 1'b0;
                    n.sel_std  = 1'b0;
                    n.sel_ext  = 1'b0;
                    n.sel_sram = 1'b0;
                    if (fault) begin
                        // Refused: no select, no write, done at once
                        n.done  = 1'b1;
                        n.err   = 1'b1;
                        n.rdata = 8'h00;
                    end else begin
                        ptr_we = gen_wb;
                        if (region == dsd_pkg::region_sram) begin
                            // Second cycle does the array access
                            n.state    = st_sram;
                            n.busy     = 1'b1;
                            n.sel_sram = 1'b1;
                        end else if (region == dsd_pkg::region_regfile) begin
                            n.done   = 1'b1;
                            n.sel_rf = 1'b1;
                            n.rdata  = rf_mem[gen_eff[4:0]];
                            rf_we    = is_store;
                        end else begin
                            n.done    = 1'b1;
                            n.sel_std = region == dsd_pkg::region_std_io;
                            n.sel_ext = region == dsd_pkg::region_ext_io;
                            io.en     = 1'b1;
                            io.we     = is_store;
                            n.rdata   = io.rdata;
                            if (is_bit) begin
                                // Only the addressed bit goes out
                                io.wmask = bit_mask;
                                io.wdata = acc_mode == dsd_pkg::set_io_bit_op
                                         ? bit_mask : 8'h00;
                                n.skip = ((io.rdata & bit_mask) != 8'h00)
                                      == (acc_mode == dsd_pkg::skip_if_io_bit_one);
                                n.skip = n.skip && !is_store;
                            end
                        end
                    end
                end
            end
            st_sram: begin
                n.state = st_idle;
                n.busy  = 1'b0;
                n.done  = 1'b1;
                sram_we = r.store;
                if (!r.store) begin
                    n.rdata = sram_mem[sram_idx];
                end
            end
            default: begin
                n.state = st_idle;
            end
        endcase
    end

    // State register; all outputs but io_flags come from here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Arrays are not reset: contents are undefined at power-up anyway
    always_ff @(posedge mclk) begin
        if (rf_we) begin
            rf_mem[gen_eff[4:0]] <= rf_wdat;
        end
        if (ptr_we) begin
            rf_mem[plo] <= gen_ptr[7:0];
            rf_mem[phi] <= gen_ptr[15:8];
        end
        if (sram_we) begin
            sram_mem[sram_idx] <= r.wdata;
        end
    end

    assign acc_rdata   = r.rdata;
    assign acc_done    = r.done;
    assign acc_err     = r.err;
    assign acc_skip    = r.skip;
    assign acc_busy    = r.busy;
    assign sel_regfile = r.sel_rf;
    assign sel_std_io  = r.sel_std;
    assign sel_ext_io  = r.sel_ext;
    assign sel_sram    = r.sel_sram;
    assign eff_addr    = r.eff_addr;

    // Pointer as stored now, for the write-back checks
    assign ptr_now = {rf_mem[{dsd_pkg::ptr_lo(r.ptr_sel) | 5'h01}],
                      rf_mem[dsd_pkg::ptr_lo(r.ptr_sel)]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_sram_two;
        (!r.done && r.busy) ##1 (r.done && !r.busy);
    endsequence

    property p_sram_two;
        take_sram |=> s_sram_two;
    endproperty
    a_sram_two: assert property (p_sram_two)
        else $error("SRAM access did not take two cycles");

    property p_fast_one;
        take && !take_sram |=> r.done;
    endproperty
    a_fast_one: assert property (p_fast_one)
        else $error("non-SRAM access not done next cycle");

    property p_one_sel;
        r.done && !r.err |-> $onehot({r.sel_rf, r.sel_std, r.sel_ext, r.sel_sram});
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("region selects not one-hot");

    property p_region;
        r.done && !r.err |->
            (r.sel_sram == (r.eff_addr >= dsd_pkg::SRAM_BASE))
            && (r.sel_rf == (r.eff_addr < dsd_pkg::STD_IO_BASE));
    endproperty
    a_region: assert property (p_region)
        else $error("region select disagrees with address");

    property p_io_offset;
        take && is_port && !fault
            |=> r.eff_addr == $past(acc_addr) + dsd_pkg::IO_DATA_OFS;
    endproperty
    a_io_offset: assert property (p_io_offset)
        else $error("port I/O address not offset by 0x20");

    property p_bit_range;
        take && is_bit && acc_addr > dsd_pkg::BIT_IO_MAX |=> r.done && r.err;
    endproperty
    a_bit_range: assert property (p_bit_range)
        else $error("bit operation above 0x1F not refused");

    property p_ext_refuse;
        take && is_port && acc_addr > dsd_pkg::IO_PORT_MAX
            |=> r.err && !r.sel_ext;
    endproperty
    a_ext_refuse: assert property (p_ext_refuse)
        else $error("port I/O reached extended I/O");

    property p_disp;
        take && acc_mode == dsd_pkg::addr_disp && !fault
            |=> r.eff_addr == $past(ptr_val) + {10'h000, $past(acc_disp)};
    endproperty
    a_disp: assert property (p_disp)
        else $error("displacement address wrong");

    property p_postinc;
        take && acc_mode == dsd_pkg::addr_postinc && !fault
            |=> r.eff_addr == $past(ptr_val)
                && ptr_now == $past(ptr_val) + dsd_pkg::PTR_STEP;
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post-increment address or write-back wrong");

    property p_predec;
        take && acc_mode == dsd_pkg::addr_predec && !fault
            |=> r.eff_addr == ptr_now
                && ptr_now == $past(ptr_val) - dsd_pkg::PTR_STEP;
    endproperty
    a_predec: assert property (p_predec)
        else $error("pre-decrement address or write-back wrong");
endmodule : dsd_data_space

/* verif/dsd_cpu_model.sv */
// CPU-side request model for the data space decoder
`timescale 1ns/100ps
module dsd_cpu_model (
    input  logic                  mclk,  // CPU clock
    input  logic                  done,  // Completion pulse
    output logic                  req,   // Access request
    output dsd_pkg::dsd_dir_type  dir,   // Load or store
    output dsd_pkg::dsd_mode_type mode,  // Addressing mode
    output logic [15:0]           addr,  // Address or I/O number
    output dsd_pkg::dsd_ptr_type  psel,  // Pointer pair
    output logic [5:0]            disp,  // Displacement
    output logic [2:0]            bitn,  // Bit number
    output logic [7:0]            wdata  // Store data
);
    int lat = 0;
    int hangs = 0;
    // Quiet request lines from time zero
    initial begin
        req   = 1'b0;
        addr  = 16'h0000;
        wdata = 8'h00;
        disp  = 6'h00;
        bitn  = 3'h0;
        mode  = dsd_pkg::addr_direct;
        dir   = dsd_pkg::data_load_ops;
        psel  = dsd_pkg::ptr_x;
    end
    // Request dropped after its take edge, else it is taken twice
    task automatic go(input int m, d, input logic [15:0] a, input logic [7:0] w,
                      input int p = 1, s = 0, b = 0);
        @(posedge mclk);
        #1;
        req   = 1'b1;
        mode  = dsd_pkg::dsd_mode_type'(m);
        dir   = dsd_pkg::dsd_dir_type'(d);
        psel  = dsd_pkg::dsd_ptr_type'(p);
        addr  = a; // Never a reserved I/O place on stores
        wdata = w;
        disp  = 6'(s);
        bitn  = 3'(b);
        @(posedge mclk);
        #1;
        req   = 1'b0;
        addr  = ~a; // Released lines do not keep the old value
        wdata = ~w;
        lat   = 1; // Take edge is the first cycle of the access
        while (done !== 1'b1 && lat < 8) begin
            @(posedge mclk);
            #1;
            lat++;
        end
        // No completion within the limit counts against the run
        if (done !== 1'b1) begin
            hangs++;
        end
    endtask : go
endmodule : dsd_cpu_model

/* verif/data_space_decoder_tb.sv */
// Self-checking bench for the data space decoder
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module data_space_decoder_tb;
    localparam int DR = 0, DS = 1, ID = 2, PD = 3, PI = 4, IO = 5, SB = 6, CB = 7, S1 = 8, S0 = 9;
    logic                  mclk, rst_n, req, acc_done, acc_err, acc_skip, busy;
    logic [7:0]            hw_flag_set, acc_rdata, io_flags, wdata;
    logic [3:0]            sel;
    logic [15:0]           eff_addr, addr;
    logic [5:0]            disp;
    logic [2:0]            bitn;
    dsd_pkg::dsd_dir_type  dir;
    dsd_pkg::dsd_mode_type mode;
    dsd_pkg::dsd_ptr_type  psel;
    int                    fail_count = 0;
    int                    n_checks   = 0;

    dsd_cpu_model cpu (.mclk(mclk), .done(acc_done), .req(req), .dir(dir), .mode(mode),
        .addr(addr), .psel(psel), .disp(disp), .bitn(bitn), .wdata(wdata));
    dsd_data_space dut (.mclk(mclk), .rst_n(rst_n), .acc_req(req), .acc_dir(dir),
        .acc_mode(mode), .acc_addr(addr), .acc_ptr_sel(psel), .acc_disp(disp),
        .acc_bit(bitn), .acc_wdata(wdata), .hw_flag_set(hw_flag_set),
        .acc_rdata(acc_rdata), .acc_done(acc_done), .acc_err(acc_err), .acc_skip(acc_skip),
        .acc_busy(busy), .sel_regfile(sel[3]), .sel_std_io(sel[2]), .sel_ext_io(sel[1]),
        .sel_sram(sel[0]), .eff_addr(eff_addr), .io_flags(io_flags));

    // Region edges, refusal past the end, SRAM latency
    task automatic t_regions;
        logic [15:0] a [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF,
                               16'h0100, 16'h08FF, 16'h0900};
        logic [3:0]  s [8] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0};
        for (int i = 0; i < 8; i++) begin
            cpu.go(DR, 0, a[i], 8'h00);
            `CHK(sel, s[i])
            `CHK(acc_err, 1'(i == 7))
        end
        cpu.go(DR, 1, 16'h0123, 8'h5A);
        `CHK(cpu.lat, 2)
        `CHK(busy, 1'b0)
        cpu.go(DR, 0, 16'h0123, 8'h00);
        `CHK(acc_rdata, 8'h5A)
    endtask : t_regions

    // Port numbering, bit access and its range
    task automatic t_io;
        cpu.go(IO, 1, 16'h001E, 8'hA5);
        `CHK(eff_addr, 16'h003E)
        cpu.go(IO, 0, 16'h0040, 8'h00);
        `CHK(acc_err, 1'b1)
        cpu.go(S1, 0, 16'h001E, 8'h00, 1, 0, 2);
        `CHK(acc_skip, 1'b1)
        cpu.go(SB, 0, 16'h001E, 8'h00, 1, 0, 1);
        `CHK(acc_skip, 1'b0)
        cpu.go(CB, 0, 16'h001E, 8'h00, 1, 0, 0);
        cpu.go(S0, 0, 16'h001E, 8'h00, 1, 0, 0);
        `CHK(acc_skip, 1'b1)
        cpu.go(DR, 0, 16'h003E, 8'h00);
        `CHK(acc_rdata, 8'hA6)
        cpu.go(SB, 0, 16'h002A, 8'h00, 1, 0, 0);
        `CHK(acc_err, 1'b1)
    endtask : t_io

    // Write-one-to-clear flags, by store and by single bit
    task automatic t_flags;
        @(posedge mclk);
        #1 hw_flag_set = 8'h0F;
        @(posedge mclk);
        #1 hw_flag_set = 8'h00;
        `CHK(io_flags, 8'h0F)
        cpu.go(DR, 1, 16'h003C, 8'h05);
        @(posedge mclk);
        #1;
        `CHK(io_flags, 8'h0A)
        cpu.go(SB, 0, 16'h001C, 8'h00, 1, 0, 3);
        @(posedge mclk);
        #1;
        `CHK(io_flags, 8'h02)
    endtask : t_flags

    // Pointer pairs, post-increment, pre-decrement, displacement
    task automatic t_ptrs;
        cpu.go(DR, 1, 16'h001A, 8'h00);
        cpu.go(DR, 1, 16'h001B, 8'h01);
        cpu.go(PI, 1, 16'h0000, 8'h77, 0);
        `CHK(eff_addr, 16'h0100)
        cpu.go(DR, 0, 16'h001A, 8'h00);
        `CHK(acc_rdata, 8'h01)
        `CHK(cpu.lat, 1)
        cpu.go(PD, 0, 16'h0000, 8'h00, 0);
        `CHK(acc_rdata, 8'h77)
        cpu.go(ID, 0, 16'h0000, 8'h00, 0);
        `CHK(acc_rdata, 8'h77)
        cpu.go(DR, 1, 16'h001C, 8'hC1);
        cpu.go(DR, 1, 16'h001D, 8'h01);
        cpu.go(DS, 0, 16'h0000, 8'h00, 1, 63);
        `CHK(eff_addr, 16'h0200)
        cpu.go(DS, 0, 16'h0000, 8'h00, 0, 1);
        `CHK(acc_err, 1'b1)
    endtask : t_ptrs

    // Counts, then verdict
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        hw_flag_set = 8'h00;
        repeat (4) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_regions();
        t_io();
        t_flags();
        t_ptrs();
        `CHK(cpu.hangs, 0)
        stop_test();
    end
endmodule : data_space_decoder_tb
